// *** rtl/wdcs_pkg.sv ***
// Package of constants and types for the watchdog clock stabilizer
package wdcs_pkg;
    // Register byte addresses
    localparam logic [31:0] WDCS_ADDR_COUNTER = 32'hFFC00008;
    localparam logic [31:0] WDCS_ADDR_CSR     = 32'hFFC0000C;
    localparam logic [31:0] WDCS_ADDR_FRQ     = 32'hFFC00000;
    // Write keys in the upper byte of a word write
    localparam logic [7:0]  WDCS_KEY_COUNTER  = 8'h5A;
    localparam logic [7:0]  WDCS_KEY_CSR      = 8'hA5;
    // Access size codes
    localparam logic [1:0]  WDCS_SIZE_BYTE    = 2'h0;
    localparam logic [1:0]  WDCS_SIZE_WORD    = 2'h1;
    localparam logic [1:0]  WDCS_SIZE_LONG    = 2'h2;
    // Control/status field positions
    localparam int          WDCS_BIT_RUN      = 7;
    localparam int          WDCS_BIT_MODE     = 6;
    localparam int          WDCS_BIT_RSTKIND  = 5;
    localparam int          WDCS_BIT_WATCHDOG_OVERFLOW_FLAG     = 4;
    localparam int          WDCS_BIT_INTERVAL_OVERFLOW_FLAG     = 3;
    localparam int          WDCS_CKS_LSB      = 0;
    localparam int          WDCS_CKS_W        = 3;
    // Reset values
    localparam logic [7:0]  WDCS_COUNTER_RST  = 8'h00;
    localparam logic [7:0]  WDCS_CSR_RST      = 8'h00;
    // Divide by 32 for select code zero: shift of 5
    localparam int          WDCS_DIV_BASE_LOG = 5;
    localparam int          WDCS_PRESCALE_W   = 12;
    // Frequency control field positions (16-bit word)
    localparam int          WDCS_FRQ_CLKOUT   = 11;
    localparam int          WDCS_FRQ_PLL1     = 10;
    localparam int          WDCS_FRQ_PLL2     = 9;
    localparam int          WDCS_FRQ_CPU_LSB  = 6;
    localparam int          WDCS_FRQ_BUS_LSB  = 3;
    localparam int          WDCS_FRQ_PER_LSB  = 0;
    localparam logic [15:0] WDCS_FRQ_RST      = 16'h0E00;

    // Stabilization sequencer states
    typedef enum logic [3:0] {
        WDCS_IDLE   = 4'b0001,
        WDCS_STAB1  = 4'b0010,
        WDCS_STAB2  = 4'b0100,
        WDCS_STABX  = 4'b1000
    } wdcs_state_t;
endpackage

// *** rtl/wdcs_watchdog_unit.sv ***
// Watchdog timer with clock stabilization sequencing
//
// Notes on behaviour
// - PLL1 on, PLL2 off: halt, count, resume
// - PLL1 on, PLL2 on: two counted phases
// - Processor held; unstable clock out allowed
// - Bus divide change, PLL2 on: stabilize
// - Bus divide change, PLL2 off: immediate
// - CPU/peripheral divide change: immediate switch
// - Clock out enable: drive or float pulled
// - 8-bit up counter; reset or interrupt
// - Power-on reset only clears registers
// - Standby stabilization overflow keeps control/status
// - Counter write: word, key 5A
// - Control/status write: word, key A5
// - Byte/long writes ignored; byte reads
// - Bit 7 runs count; clear holds except while stabilization runs
// - Bit 6: interval zero, watchdog one
// - Bit 5: power-on or manual reset
// - Watchdog flag set only in watchdog mode
// - Interval flag set only in interval mode
// - Select divides by 32 up to 4096
// - Count clock is post-switch clock
// - Watchdog overflow: flag, reset, keep counting
// - Interval overflow: flag, interrupt, keep counting
// - Stabilization stop leaves counter near zero
`timescale 1ns/1ps
module wdcs_watchdog_unit
    import wdcs_pkg::*;
#(
    parameter int COUNT_W = 8
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    input  wire logic [31:0] addr,
    input  wire logic [1:0]  size,
    input  wire logic [15:0] wdata,
    output logic      [7:0]  rdata,
    input  wire logic        standby_wake,
    output logic             cpu_halt,
    output logic             clock_unstable,
    output logic             pll_one_run,
    output logic             pll_two_run,
    output logic      [2:0]  cpu_divide_now,
    output logic      [2:0]  bus_divide_now,
    output logic      [2:0]  peripheral_divide_now,
    output logic             clock_out_pin_o,
    output logic             clock_out_pin_oe_n,
    output logic             poweron_reset_req,
    output logic             manual_reset_req,
    output logic             interval_irq
);
    // Whole state of the block
    typedef struct packed {
        logic [COUNT_W-1:0]   counter;
        logic [COUNT_W-1:0]   stab_init;
        logic [7:0]           csr;
        logic [15:0]          frq;
        logic [WDCS_PRESCALE_W-1:0] prescale;
        wdcs_state_t          state;
        logic                 standby_phase;
        logic                 wake_s1;
        logic                 wake_s2;
        logic [7:0]           rdata;
        logic                 cpu_halt;
        logic                 unstable;
        logic                 pll1;
        logic                 pll2;
        logic [2:0]           cpu_div;
        logic [2:0]           bus_div;
        logic [2:0]           per_div;
        logic                 clk_out;
        logic                 clk_oe_n;
        logic                 por_req;
        logic                 man_req;
        logic                 irq;
    } wdcs_regs_t;

    wdcs_regs_t r;
    wdcs_regs_t next_r;

    // Count tick: prescaler bit for selected divide ratio toggles
    function automatic logic wdcs_tick(input logic [WDCS_PRESCALE_W-1:0] p,
                                       input logic [2:0] sel);
        logic [WDCS_PRESCALE_W-1:0] mask;
        mask = (WDCS_PRESCALE_W'(1) << (WDCS_DIV_BASE_LOG + int'(sel))) - WDCS_PRESCALE_W'(1);
        return (p & mask) == mask;
    endfunction

    // Word write with matching key
    function automatic logic wdcs_keyed(input logic [31:0] a, input logic [1:0] s,
                                        input logic [15:0] d, input logic [31:0] ta,
                                        input logic [7:0] key);
        return (a == ta) && (s == WDCS_SIZE_WORD) && (d[15:8] == key);
    endfunction

    logic        tick;
    logic        ovf;
    logic        counting;
    logic        wr_cnt;
    logic        wr_csr;
    logic        wr_frq;
    logic [15:0] nf;

    // Next-state logic
    always_comb begin
        next_r = r;
        tick = wdcs_tick(r.prescale, r.csr[WDCS_CKS_LSB +: WDCS_CKS_W]);
        wr_cnt = wr_en && wdcs_keyed(addr, size, wdata, WDCS_ADDR_COUNTER,
                                     WDCS_KEY_COUNTER);
        wr_csr = wr_en && wdcs_keyed(addr, size, wdata, WDCS_ADDR_CSR,
                                     WDCS_KEY_CSR);
        // Frequency control is taken only as a whole word
        wr_frq = wr_en && (size == WDCS_SIZE_WORD) && (addr == WDCS_ADDR_FRQ);
        nf = wdata;
        counting = r.csr[WDCS_BIT_RUN] || (r.state != WDCS_IDLE);
        ovf = counting && tick && (r.counter == {COUNT_W{1'b1}});
        next_r.prescale = r.prescale + WDCS_PRESCALE_W'(1);
        next_r.por_req = 1'b0;
        next_r.man_req = 1'b0;
        next_r.irq = 1'b0;
        // Standby wake synchroniser
        next_r.wake_s1 = standby_wake;
        next_r.wake_s2 = r.wake_s1;
        // Counter advance
        if (counting && tick) begin
            next_r.counter = r.counter + COUNT_W'(1);
        end
        // Ordinary overflow handling when no stabilization runs
        if (ovf && r.state == WDCS_IDLE) begin
            if (r.csr[WDCS_BIT_MODE]) begin
                next_r.csr[WDCS_BIT_WATCHDOG_OVERFLOW_FLAG] = 1'b1;
                next_r.por_req = !r.csr[WDCS_BIT_RSTKIND];
                next_r.man_req = r.csr[WDCS_BIT_RSTKIND];
            end else begin
                next_r.csr[WDCS_BIT_INTERVAL_OVERFLOW_FLAG] = 1'b1;
                next_r.irq = 1'b1;
            end
        end
        // Stabilization sequencer
        case (r.state)
            WDCS_IDLE: begin
                if (wr_frq) begin
                    next_r.frq = nf;
                    next_r.cpu_div = nf[WDCS_FRQ_CPU_LSB +: 3];
                    next_r.per_div = nf[WDCS_FRQ_PER_LSB +: 3];
                    next_r.clk_oe_n = !nf[WDCS_FRQ_CLKOUT];
                    next_r.pll2 = nf[WDCS_FRQ_PLL2];
                    next_r.pll1 = nf[WDCS_FRQ_PLL1];
                    if (nf[WDCS_FRQ_PLL1] && !r.frq[WDCS_FRQ_PLL1]) begin
                        next_r.pll2 = 1'b0;
                        next_r.state = r.frq[WDCS_FRQ_PLL2] ? WDCS_STAB2 : WDCS_STAB1;
                    end else if (nf[WDCS_FRQ_BUS_LSB +: 3] != r.frq[WDCS_FRQ_BUS_LSB +: 3]
                                 && r.frq[WDCS_FRQ_PLL2]) begin
                        next_r.state = WDCS_STAB1;
                    end else begin
                        next_r.bus_div = nf[WDCS_FRQ_BUS_LSB +: 3];
                    end
                    if (next_r.state != WDCS_IDLE) begin
                        next_r.cpu_halt = 1'b1;
                        // Remember the preset for the second phase reload
                        next_r.stab_init = r.counter;
                        next_r.unstable = 1'b1;
                    end
                end else if (r.wake_s2 && !r.csr[WDCS_BIT_RUN]) begin
                    next_r.state = WDCS_STABX;
                    next_r.cpu_halt = 1'b1;
                end
            end
            WDCS_STAB2: begin
                if (ovf) begin
                    next_r.pll2 = 1'b1;
                    next_r.counter = r.stab_init;
                    next_r.state = WDCS_STAB1;
                end
            end
            WDCS_STAB1, WDCS_STABX: begin
                if (ovf) begin
                    next_r.state = WDCS_IDLE;
                    next_r.cpu_halt = 1'b0;
                    next_r.unstable = 1'b0;
                    next_r.bus_div = r.frq[WDCS_FRQ_BUS_LSB +: 3];
                end
            end
            default: begin
                next_r.state = WDCS_IDLE;
            end
        endcase
        // Register writes (flags not set by stabilization overflows)
        if (wr_cnt) begin
            next_r.counter = wdata[COUNT_W-1:0];
        end
        if (wr_csr) begin
            next_r.csr = wdata[7:0];
            if (next_r.csr[WDCS_BIT_WATCHDOG_OVERFLOW_FLAG] == 1'b0
                && ovf && r.state == WDCS_IDLE && r.csr[WDCS_BIT_MODE]) begin
                next_r.csr[WDCS_BIT_WATCHDOG_OVERFLOW_FLAG] = 1'b1;
            end
            if (next_r.csr[WDCS_BIT_INTERVAL_OVERFLOW_FLAG] == 1'b0
                && ovf && r.state == WDCS_IDLE && !r.csr[WDCS_BIT_MODE]) begin
                next_r.csr[WDCS_BIT_INTERVAL_OVERFLOW_FLAG] = 1'b1;
            end
        end
        // Byte reads of either register
        next_r.rdata = 8'h00;
        if (rd_en && addr == WDCS_ADDR_COUNTER) begin
            next_r.rdata = 8'(r.counter);
        end else if (rd_en && addr == WDCS_ADDR_CSR) begin
            next_r.rdata = r.csr;
        end
        // Clock out pin: drive when enabled
        next_r.clk_out = r.prescale[0];
    end

    // State register, loaded with its reset values only by the power-on reset pin
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
            r.state <= WDCS_IDLE;
            r.frq <= WDCS_FRQ_RST;
            r.pll1 <= 1'b1;
            r.pll2 <= 1'b1;
            r.counter <= WDCS_COUNTER_RST;
            r.csr <= WDCS_CSR_RST;
        end else if (clk_en) begin
            r <= next_r;
        end
    end

    // Outputs straight from flip-flops
    assign rdata                 = r.rdata;
    assign cpu_halt              = r.cpu_halt;
    assign clock_unstable        = r.unstable;
    assign pll_one_run           = r.pll1;
    assign pll_two_run           = r.pll2;
    assign cpu_divide_now        = r.cpu_div;
    assign bus_divide_now        = r.bus_div;
    assign peripheral_divide_now = r.per_div;
    assign clock_out_pin_o       = r.clk_out;
    assign clock_out_pin_oe_n    = r.clk_oe_n;
    assign poweron_reset_req     = r.por_req;
    assign manual_reset_req      = r.man_req;
    assign interval_irq          = r.irq;

    // Checks on the timer
    a_watchdog_overflow_flag_mode_only: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && ovf && r.state == WDCS_IDLE && !wr_csr && r.csr[WDCS_BIT_MODE]
        |=> r.csr[WDCS_BIT_WATCHDOG_OVERFLOW_FLAG] && poweron_reset_req != manual_reset_req)
        else $error("watchdog overflow did not flag");
    a_interval_overflow_flag_irq_pulse: assert property (@(posedge clk) disable iff (!reset_n)
        interval_irq |-> r.csr[WDCS_BIT_INTERVAL_OVERFLOW_FLAG] && !r.csr[WDCS_BIT_MODE])
        else $error("interrupt without interval flag");
    a_reset_req_flag: assert property (@(posedge clk) disable iff (!reset_n)
        poweron_reset_req || manual_reset_req
        |-> r.csr[WDCS_BIT_WATCHDOG_OVERFLOW_FLAG] && r.csr[WDCS_BIT_MODE])
        else $error("reset request without watchdog flag");
    a_halt_unstable: assert property (@(posedge clk) disable iff (!reset_n)
        clock_unstable |-> cpu_halt)
        else $error("unstable clock without halt");
    a_counter_holds: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && !counting && !wr_cnt |=> $stable(r.counter))
        else $error("counter moved while stopped");
    a_bad_write_ignored: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && wr_en && size != WDCS_SIZE_WORD && !counting |=> $stable(r.counter))
        else $error("non-word write changed counter");

    // Checks on the stabilization sequence and frequency control
    a_halt_ends_ovf: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(cpu_halt) |-> r.counter <= 8'h01)
        else $error("stabilization stop value wrong");
    a_stab_starts: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && wr_frq && r.state == WDCS_IDLE && wdata[WDCS_FRQ_PLL1]
        && !r.frq[WDCS_FRQ_PLL1] |=> cpu_halt && clock_unstable)
        else $error("pll start did not halt");
    a_stab_reload: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && r.state == WDCS_STAB2 && ovf && !wr_cnt
        |=> r.counter == r.stab_init && pll_two_run)
        else $error("second phase did not reload");
    a_stab_flags_quiet: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && ovf && r.state != WDCS_IDLE && !wr_csr |=> $stable(r.csr))
        else $error("stabilization overflow changed status");
    a_clkout_enable: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && wr_frq && r.state == WDCS_IDLE
        |=> clock_out_pin_oe_n == !$past(wdata[WDCS_FRQ_CLKOUT]))
        else $error("clock out enable wrong");
    a_div_immediate: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && wr_frq && r.state == WDCS_IDLE
        |=> cpu_divide_now == $past(wdata[WDCS_FRQ_CPU_LSB +: 3]))
        else $error("cpu divide not immediate");
    a_bus_immediate: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && wr_frq && r.state == WDCS_IDLE && !r.frq[WDCS_FRQ_PLL2]
        && !(wdata[WDCS_FRQ_PLL1] && !r.frq[WDCS_FRQ_PLL1])
        |=> bus_divide_now == $past(wdata[WDCS_FRQ_BUS_LSB +: 3]))
        else $error("bus divide not immediate");
endmodule

// *** test/wdcs_core_model.sv ***
// Processor core model issuing register accesses
`timescale 1ns/1ps
module wdcs_core_model import wdcs_pkg::*; (
    input  wire logic        clk,
    input  wire logic        cpu_halt,
    output logic             wr_en,
    output logic             rd_en,
    output logic      [31:0] addr,
    output logic      [1:0]  size,
    output logic      [15:0] wdata
);
    // Bus idle from time zero
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 32'h0;
        size = 2'h0;
        wdata = 16'h0;
    end

    // One access held to its taking edge, lines scrambled after
    task automatic access(input logic w, input logic [31:0] a,
                          input logic [1:0] s, input logic [15:0] d);
        @(posedge clk);
        #1;
        while (cpu_halt === 1'b1) begin
            @(posedge clk);
            #1;
        end
        wr_en = w;
        rd_en = !w;
        addr = a;
        size = s;
        wdata = d;
        @(posedge clk);
        #1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask

    // Keyed word writes and byte reads
    task automatic put_counter(input logic [7:0] v);
        access(1'b1, WDCS_ADDR_COUNTER, WDCS_SIZE_WORD, {WDCS_KEY_COUNTER, v});
    endtask
    task automatic put_csr(input logic [7:0] v);
        access(1'b1, WDCS_ADDR_CSR, WDCS_SIZE_WORD, {WDCS_KEY_CSR, v});
    endtask
    task automatic get(input logic [31:0] a);
        access(1'b0, a, WDCS_SIZE_BYTE, 16'h0);
    endtask
endmodule

// *** test/tb_watchdog_clock_stabilizer.sv ***
// Self-checking bench for the watchdog clock stabilizer
`timescale 1ns/1ps
module tb_watchdog_clock_stabilizer import wdcs_pkg::*;;
    logic        clk, reset_n, clk_en, standby_wake, wr_en, rd_en;
    logic        rd_seen = 1'b0;
    logic [31:0] addr;
    logic [1:0]  size;
    logic [15:0] wdata, note;
    logic [7:0]  rdata, v, k;
    logic        cpu_halt, clock_unstable, pll_one_run, pll_two_run;
    logic [2:0]  cpu_divide_now, bus_divide_now, peripheral_divide_now;
    logic        clock_out_pin_o, clock_out_pin_oe_n;
    logic        poweron_reset_req, manual_reset_req, interval_irq;
    logic [15:0] expq[$];
    int          n_fail = 0;
    int          comparisons = 0;
    int          n;

    wdcs_watchdog_unit dut_u (
        .clk                   (clk),
        .reset_n               (reset_n),
        .clk_en                (clk_en),
        .wr_en                 (wr_en),
        .rd_en                 (rd_en),
        .addr                  (addr),
        .size                  (size),
        .wdata                 (wdata),
        .rdata                 (rdata),
        .standby_wake          (standby_wake),
        .cpu_halt              (cpu_halt),
        .clock_unstable        (clock_unstable),
        .pll_one_run           (pll_one_run),
        .pll_two_run           (pll_two_run),
        .cpu_divide_now        (cpu_divide_now),
        .bus_divide_now        (bus_divide_now),
        .peripheral_divide_now (peripheral_divide_now),
        .clock_out_pin_o       (clock_out_pin_o),
        .clock_out_pin_oe_n    (clock_out_pin_oe_n),
        .poweron_reset_req     (poweron_reset_req),
        .manual_reset_req      (manual_reset_req),
        .interval_irq          (interval_irq)
    );
    wdcs_core_model core_u (.clk(clk), .cpu_halt(cpu_halt), .wr_en(wr_en), .rd_en(rd_en),
                            .addr(addr), .size(size), .wdata(wdata));

    task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic rd(input logic [31:0] a, input logic [7:0] m, input logic [7:0] e);
        expq.push_back({m, e});
        core_u.get(a);
    endtask
    task automatic frq(input logic [15:0] f);
        core_u.access(1'b1, WDCS_ADDR_FRQ, WDCS_SIZE_WORD, f);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Stopped timer preset, then a frequency write and halt span measure
    task automatic stab(input logic [15:0] f, input int lo, input int hi);
        core_u.put_counter(8'hF0);
        frq(f);
        n = 0;
        while (cpu_halt !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("unstable clock", 16'h1, {15'h0, clock_unstable});
        n = 0;
        while (cpu_halt === 1'b1 && n < 20000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("halt span", 16'h1, {15'h0, n >= lo && n <= hi});
        rd(WDCS_ADDR_COUNTER, 8'hFE, 8'h00);
    endtask

    // Clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Read answers against the oldest expectation
    always @(posedge clk) begin
        if (rd_seen === 1'b1) begin
            note = expq.pop_front();
            check("read data", {8'h0, note[7:0]}, {8'h0, rdata & note[15:8]});
        end
        rd_seen <= rd_en;
    end
    // Hang guard
    initial begin
        #1400000;
        n_fail++;
        stop_test();
    end
    // Main sequence
    initial begin
        reset_n = 1'b0;
        clk_en = 1'b1;
        standby_wake = 1'b0;
        void'($urandom(32'hB1C6));
        repeat (2) @(posedge clk);
        #1;
        reset_n = 1'b1;
        rd(WDCS_ADDR_COUNTER, 8'hFF, WDCS_COUNTER_RST);
        rd(WDCS_ADDR_CSR, 8'hFF, WDCS_CSR_RST);
        check("pll runs", 16'h3, {14'h0, pll_one_run, pll_two_run});
        v = 8'($urandom) | 8'h01;
        k = WDCS_KEY_COUNTER ^ (8'($urandom) | 8'h01);
        core_u.access(1'b1, WDCS_ADDR_COUNTER, WDCS_SIZE_BYTE, {WDCS_KEY_COUNTER, v});
        core_u.access(1'b1, WDCS_ADDR_COUNTER, WDCS_SIZE_LONG, {WDCS_KEY_COUNTER, v});
        core_u.access(1'b1, WDCS_ADDR_COUNTER, WDCS_SIZE_WORD, {k, v});
        core_u.access(1'b1, WDCS_ADDR_CSR, WDCS_SIZE_WORD, {WDCS_KEY_COUNTER, v});
        rd(WDCS_ADDR_COUNTER, 8'hFF, 8'h00);
        rd(WDCS_ADDR_CSR, 8'hFF, 8'h00);
        core_u.put_counter(v);
        rd(WDCS_ADDR_COUNTER, 8'hFF, v);
        core_u.put_csr(8'h27);
        rd(WDCS_ADDR_CSR, 8'hFF, 8'h27);
        $display("test register access done");
        for (int s = 0; s < 8; s++) begin
            core_u.put_csr(8'h00);
            core_u.put_counter(8'hFE);
            core_u.put_csr({5'b10000, 3'(s)});
            n = 0;
            while (interval_irq !== 1'b1 && n < 300000) begin
                @(posedge clk);
                #1;
                n++;
            end
            check("tick span", 16'h1, {15'h0, n >= (32 << s) - 2 && n <= (64 << s) + 4});
            rd(WDCS_ADDR_CSR, 8'hFF, {5'b10001, 3'(s)});
            core_u.put_csr(8'h00);
            repeat (40) @(posedge clk);
            rd(WDCS_ADDR_COUNTER, 8'hFF, 8'h00);
        end
        $display("test interval mode done");
        for (int r = 0; r < 2; r++) begin
            core_u.put_counter(8'hFF);
            core_u.put_csr({2'b11, 1'(r), 5'h00});
            n = 0;
            while (poweron_reset_req !== 1'b1 && manual_reset_req !== 1'b1 && n < 200) begin
                @(posedge clk);
                #1;
                n++;
            end
            check("reset kind", {14'h0, 1'(r), 1'(!r)}, {14'h0, manual_reset_req, poweron_reset_req});
            rd(WDCS_ADDR_CSR, 8'hFF, {2'b11, 1'(r), 5'h10});
            core_u.put_csr(8'h00);
        end
        $display("test watchdog mode done");
        frq(16'h0800);
        stab(16'h0C00, 470, 560);
        frq(16'h0800);
        frq(16'h0A00);
        stab(16'h0E00, 960, 1100);
        stab(16'h0E08, 470, 560);
        check("bus divide", 16'h1, {13'h0, bus_divide_now});
        frq(16'h0C08);
        frq(16'h0C10);
        check("bus divide", 16'h2, {13'h0, bus_divide_now});
        check("halted", 16'h0, {15'h0, cpu_halt});
        frq(16'h0C51);
        check("cpu periph", 16'h9, {10'h0, cpu_divide_now, peripheral_divide_now});
        check("pin driven", 16'h0, {15'h0, clock_out_pin_oe_n});
        frq(16'h0451);
        check("pin floated", 16'h1, {15'h0, clock_out_pin_oe_n});
        $display("test frequency change done");
        // Clock enable low freezes count and clock out
        core_u.put_counter(8'hFE);
        core_u.put_csr(8'h80);
        clk_en = 1'b0;
        k = {7'h0, clock_out_pin_o};
        n = 0;
        repeat (100 + $urandom % 200) begin
            @(posedge clk);
            #1;
            n += int'(interval_irq) + int'(clock_out_pin_o !== k[0]);
        end
        check("frozen", 16'h0, 16'(n));
        clk_en = 1'b1;
        n = 0;
        while (interval_irq !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("thawed span", 16'h1, {15'h0, n >= 33 && n <= 66});
        k[0] = clock_out_pin_o;
        @(posedge clk);
        #1;
        check("clock out", {15'h0, !k[0]}, {15'h0, clock_out_pin_o});
        core_u.put_csr(8'h00);
        $display("test clock enable done");
        // Standby exit count leaves control/status as written
        core_u.put_counter(8'hF8);
        core_u.put_csr(8'h20);
        standby_wake = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        standby_wake = 1'b0;
        n = 0;
        while (cpu_halt === 1'b1 && n < 2000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("standby span", 16'h1, {15'h0, n >= 200 && n <= 260});
        rd(WDCS_ADDR_CSR, 8'hFF, 8'h20);
        rd(WDCS_ADDR_COUNTER, 8'hFE, 8'h00);
        $display("test standby exit done");
        repeat (4) @(posedge clk);
        stop_test();
    end
endmodule
